// ===== src/timer_timebase_and_channel0_value.sv
// Purpose: Time-base core of a timer with counter, prescaler, reload limit and channel 0 value.
// Assumes: Mode, shadow enable, capture and update requests come from logic on the same clock.
// Notes:   The counter counts up from zero to the reload limit and then wraps.

`default_nettype none

module timer_timebase_and_channel0_value
	import timer_timebase_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              clk_en_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output var  logic [DATA_W-1:0] reg_rdata_o,
	input  wire logic              counter_enable_i,
	input  wire logic              update_request_i,
	input  wire logic              channel0_input_mode_i,
	input  wire logic              channel0_shadow_en_i,
	input  wire logic              capture_event_i,
	output var  logic              update_event_o,
	output var  logic              compare_match_o
);

	// Software-visible fields.
	logic [FIELD_W-1:0] counter_count_field;
	logic [FIELD_W-1:0] prescaler_divisor_field;
	logic [FIELD_W-1:0] reload_limit_field;
	logic [FIELD_W-1:0] channel0_match_value;

	// Working copies and internal state.
	logic [FIELD_W-1:0] prescaler_shadow;
	logic [FIELD_W-1:0] compare_shadow;
	logic [FIELD_W-1:0] compare_value;
	logic [FIELD_W-1:0] prescaler_count;

	// Decoded strobes and events.
	logic               wr_counter;
	logic               wr_prescaler;
	logic               wr_reload;
	logic               wr_channel0;
	logic               counter_tick;
	logic               counter_wrap;
	logic               update_event;
	logic               compare_equal;
	logic [DATA_W-1:0]  next_rdata;

	// Write address decoding.
	always_comb
	begin
		wr_counter   = 1'b0;
		wr_prescaler = 1'b0;
		wr_reload    = 1'b0;
		wr_channel0  = 1'b0;
		if (reg_wr_i && reg_addr_i == OFFSET_COUNTER_VALUE)
		begin
			wr_counter = 1'b1;
		end
		else if (reg_wr_i && reg_addr_i == OFFSET_PRESCALER_DIVISOR)
		begin
			wr_prescaler = 1'b1;
		end
		else if (reg_wr_i && reg_addr_i == OFFSET_AUTO_RELOAD_LIMIT)
		begin
			wr_reload = 1'b1;
		end
		else if (reg_wr_i && reg_addr_i == OFFSET_CHANNEL0_MATCH_VALUE)
		begin
			wr_channel0 = 1'b1;
		end
	end

	// The counter steps when the prescaler count reaches the divisor held in the shadow.
	assign counter_tick = counter_enable_i && (prescaler_count == prescaler_shadow); // [R3]

	// A step at the reload limit wraps; a counter write in the same cycle takes precedence.
	assign counter_wrap = counter_tick && (counter_count_field == reload_limit_field); // [R11]

	// An update comes from the wrap or from a request by the rest of the timer.
	assign update_event = update_request_i || (counter_wrap && !wr_counter);

	// Prescaler count restarts on every update so a new divisor starts from a clean phase.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			prescaler_count <= RESET_FIELD;
		end
		else if (clk_en_i)
		begin
			if (update_event || counter_tick)
			begin
				prescaler_count <= RESET_FIELD; // [R3]
			end
			else if (counter_enable_i)
			begin
				prescaler_count <= prescaler_count + COUNT_STEP; // [R3]
			end
		end
	end

	// Running counter: software write, then update request, then normal stepping.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			counter_count_field <= RESET_FIELD;
		end
		else if (clk_en_i)
		begin
			if (wr_counter)
			begin
				counter_count_field <= reg_wdata_i[FIELD_MSB:FIELD_LSB]; // [R2]
			end
			else if (update_request_i || counter_wrap)
			begin
				counter_count_field <= RESET_FIELD; // [R11]
			end
			else if (counter_tick)
			begin
				counter_count_field <= counter_count_field + COUNT_STEP;
			end
		end
	end

	// Prescaler and reload preload registers take whatever software writes.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			prescaler_divisor_field <= RESET_FIELD;
			reload_limit_field      <= RESET_FIELD;
		end
		else if (clk_en_i)
		begin
			if (wr_prescaler)
			begin
				prescaler_divisor_field <= reg_wdata_i[FIELD_MSB:FIELD_LSB];
			end
			if (wr_reload)
			begin
				reload_limit_field <= reg_wdata_i[FIELD_MSB:FIELD_LSB]; // [R11]
			end
		end
	end

	// Channel 0 value: a capture wins, and writes are dropped in input mode.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			channel0_match_value <= RESET_FIELD;
		end
		else if (clk_en_i)
		begin
			if (channel0_input_mode_i && capture_event_i)
			begin
				channel0_match_value <= counter_count_field; // [R6]
			end
			else if (wr_channel0 && !channel0_input_mode_i)
			begin
				channel0_match_value <= reg_wdata_i[FIELD_MSB:FIELD_LSB]; // [R7]
			end
		end
	end

	// Prescaler divisor only reaches the divider through its shadow at an update.
	shadow_register #(
		.WIDTH     (FIELD_W)
	) u_prescaler_shadow (
		.core_clk_i(core_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.load_i    (update_event), // [R4]
		.preload_i (prescaler_divisor_field),
		.shadow_o  (prescaler_shadow)
	);

	// Compare shadow follows the preload at updates, or every cycle when disabled.
	shadow_register #(
		.WIDTH     (FIELD_W)
	) u_compare_shadow (
		.core_clk_i(core_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.load_i    (update_event || !channel0_shadow_en_i), // [R9]
		.preload_i (channel0_match_value),
		.shadow_o  (compare_shadow)
	);

	// Without the shadow the written value compares at once.
	assign compare_value = channel0_shadow_en_i ? compare_shadow : channel0_match_value; // [R9]
	assign compare_equal = !channel0_input_mode_i && (counter_count_field == compare_value);

	// Event outputs are registered one cycle after their cause.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			update_event_o  <= 1'b0;
			compare_match_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			update_event_o  <= update_event;
			compare_match_o <= compare_equal; // [R8]
		end
	end

	// Read multiplexer; reserved bits and unmapped addresses read as zero.
	always_comb
	begin
		next_rdata = UNMAPPED_READ;
		if (reg_addr_i == OFFSET_COUNTER_VALUE)
		begin
			next_rdata = {UPPER_ZERO, counter_count_field}; // [R1]
		end
		else if (reg_addr_i == OFFSET_PRESCALER_DIVISOR)
		begin
			next_rdata = {UPPER_ZERO, prescaler_divisor_field};
		end
		else if (reg_addr_i == OFFSET_AUTO_RELOAD_LIMIT)
		begin
			next_rdata = {UPPER_ZERO, reload_limit_field};
		end
		else if (reg_addr_i == OFFSET_CHANNEL0_MATCH_VALUE)
		begin
			next_rdata = {UPPER_ZERO, channel0_match_value};
		end
	end

	// Read data stand for exactly the cycle after the read strobe.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			reg_rdata_o <= RESET_WORD;
		end
		else if (clk_en_i)
		begin
			if (reg_rd_i)
			begin
				reg_rdata_o <= next_rdata; // [R1]
			end
			else
			begin
				reg_rdata_o <= RESET_WORD;
			end
		end
	end

	// Checks on the behaviour above, all in the core clock domain.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// A normal wrap: a step at the limit without a competing write.
	sequence seq_wrap_cause;
		clk_en_i && counter_wrap && !wr_counter && !update_request_i;
	endsequence

	// The wrap result: count at zero and the update pulse out together.
	sequence seq_wrap_effect;
		counter_count_field == RESET_FIELD && update_event_o;
	endsequence

	// A capture in input mode.
	sequence seq_capture_cause;
		clk_en_i && channel0_input_mode_i && capture_event_i;
	endsequence

	chk_count_readback: assert property ( // [R1]
		clk_en_i && reg_rd_i && reg_addr_i == OFFSET_COUNTER_VALUE
		|=> reg_rdata_o == {UPPER_ZERO, $past(counter_count_field)})
		else $error("Counter read returned a wrong value.");

	chk_count_write: assert property ( // [R2]
		clk_en_i && wr_counter
		|=> counter_count_field == $past(reg_wdata_i[FIELD_MSB:FIELD_LSB]))
		else $error("Counter write did not replace the count.");

	chk_prescale_bound: assert property ( // [R3]
		prescaler_count <= prescaler_shadow)
		else $error("Prescaler count passed its divisor.");

	chk_prescale_step: assert property ( // [R3]
		clk_en_i && counter_enable_i && !counter_tick && !update_event && !wr_counter
		|=> prescaler_count == $past(prescaler_count) + COUNT_STEP
		&& counter_count_field == $past(counter_count_field))
		else $error("Counter stepped before the divisor was reached.");

	chk_prescale_hold: assert property ( // [R4]
		clk_en_i && !update_event |=> $stable(prescaler_shadow))
		else $error("Prescaler shadow changed outside an update.");

	chk_prescale_load: assert property ( // [R4]
		clk_en_i && update_event |=> prescaler_shadow == $past(prescaler_divisor_field))
		else $error("Prescaler shadow missed an update.");

	chk_capture_load: assert property ( // [R6]
		seq_capture_cause |=> channel0_match_value == $past(counter_count_field))
		else $error("Capture did not load the count.");

	chk_input_readonly: assert property ( // [R7]
		clk_en_i && channel0_input_mode_i && !capture_event_i
		|=> $stable(channel0_match_value))
		else $error("Channel 0 value changed in input mode without capture.");

	chk_compare_out: assert property ( // [R8]
		clk_en_i && !channel0_input_mode_i
		|=> compare_match_o == ($past(counter_count_field) == $past(compare_value)))
		else $error("Compare output does not follow the match.");

	chk_compare_shadow: assert property ( // [R9]
		clk_en_i && channel0_shadow_en_i && !update_event |=> $stable(compare_shadow))
		else $error("Compare shadow changed outside an update.");

	chk_reload_wrap: assert property ( // [R11]
		seq_wrap_cause |=> seq_wrap_effect)
		else $error("Counter did not wrap at the reload limit.");

	// Read data fall back to zero in every clock-enabled cycle without a read strobe.
	chk_rdata_idle: assert property ( // [R1]
		clk_en_i && !reg_rd_i |=> reg_rdata_o == RESET_WORD)
		else $error("Read data stood without a read strobe.");

	chk_reload_write: assert property ( // [R11]
		clk_en_i && wr_reload
		|=> reload_limit_field == $past(reg_wdata_i[FIELD_MSB:FIELD_LSB]))
		else $error("Reload limit write was lost.");

	chk_prescale_write: assert property ( // [R4]
		clk_en_i && wr_prescaler
		|=> prescaler_divisor_field == $past(reg_wdata_i[FIELD_MSB:FIELD_LSB]))
		else $error("Prescaler write did not reach the preload.");

	chk_compare_input: assert property ( // [R8]
		clk_en_i && channel0_input_mode_i |=> !compare_match_o)
		else $error("Compare output raised in input mode.");

	// A low clock enable freezes the count and the update event output.
	chk_freeze_count: assert property (
		!clk_en_i |=> $stable(counter_count_field) && $stable(update_event_o))
		else $error("State moved while the clock enable was low.");

endmodule : timer_timebase_and_channel0_value

`default_nettype wire

// ===== shared/timer_timebase_pkg.sv
// Purpose: Shared constants for the timer time-base and channel 0 value block.
// Assumes: Byte addresses on an 8-bit register address, one 32-bit word per register.
// Notes:   All register contents reset to zero; only bits 15:0 of each register are used.
// Behaviour
// [R1] A read of the counter value register returns the current 16-bit count in bits 15:0.
// [R2] A write to the counter field replaces the running count with the written value.
// [R3] The counter advances once per prescaler divisor plus one kernel clock cycles.
// [R4] A written prescaler divisor takes effect only through its shadow, loaded at each update.
// [R5] Software reaches the prescaler and channel 0 value registers only with whole words.
// [R6] In input mode the channel 0 value is loaded with the count at each capture event.
// [R7] In input mode the channel 0 value ignores software writes.
// [R8] In output mode the channel 0 value is compared against the counter.
// [R9] With its shadow enabled, the channel 0 compare value moves to the shadow at each update.
// [R10] Software writes the reserved bits 31:16 of these registers as zero.
// [R11] The auto-reload limit sets where the counter wraps to zero and raises an update.
// [R12] For input capture, software sets a non-zero reload limit above any expected capture.

`default_nettype none

package timer_timebase_pkg;

	// Register bus geometry.
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned FIELD_W = 16;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFFSET_COUNTER_VALUE = 8'h24;
	localparam logic [ADDR_W-1:0] OFFSET_PRESCALER_DIVISOR = 8'h28;
	localparam logic [ADDR_W-1:0] OFFSET_AUTO_RELOAD_LIMIT = 8'h2c;
	localparam logic [ADDR_W-1:0] OFFSET_CHANNEL0_MATCH_VALUE = 8'h34;

	// Field layout shared by all four registers.
	localparam int unsigned FIELD_LSB = 0;
	localparam int unsigned FIELD_MSB = 15;

	// Reset values.
	localparam logic [FIELD_W-1:0] RESET_FIELD = 16'h0000;
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
	localparam logic [FIELD_W-FIELD_W/2-1:0] RESERVED_ZERO = 8'h00;
	localparam logic [FIELD_W-1:0] UPPER_ZERO = 16'h0000;

	// Counting step.
	localparam logic [FIELD_W-1:0] COUNT_STEP = 16'h0001;

endpackage : timer_timebase_pkg

`default_nettype wire

// ===== src/shadow_register.sv
// Purpose: Shadow copy of a preload value, taken over on a load strobe.
// Assumes: Load is a strobe on the same clock; held high, the shadow follows the preload.
// Notes:   Frozen while the clock enable is low.

`default_nettype none

module shadow_register
	import timer_timebase_pkg::*;
#(
	parameter int unsigned WIDTH = FIELD_W
)
(
	input  wire logic             core_clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clk_en_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] preload_i,
	output var  logic [WIDTH-1:0] shadow_o
);

	// The shadow only changes on the load strobe, so the working value stays steady.
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			shadow_o <= '0;
		end
		else if (clk_en_i && load_i)
		begin
			shadow_o <= preload_i;
		end
	end

endmodule : shadow_register

`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the timer time-base and channel 0 value block.
// Assumes: Clock enable high outside its own scenario; registers reached through the strobe port.
// Notes:   The count is stopped before each counter check so expected values stay exact.

`default_nettype none

module testbench
	import timer_timebase_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;

	logic              core_clk_i            = 1'b0;
	logic              reset_n_i             = 1'b0;
	logic              clk_en_i              = 1'b1;
	logic [ADDR_W-1:0] reg_addr_i            = 8'h00;
	logic [DATA_W-1:0] reg_wdata_i           = 32'h00000000;
	logic              reg_wr_i              = 1'b0;
	logic              reg_rd_i              = 1'b0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic              counter_enable_i      = 1'b0;
	logic              update_request_i      = 1'b0;
	logic              channel0_input_mode_i = 1'b0;
	logic              channel0_shadow_en_i  = 1'b0;
	logic              capture_event_i       = 1'b0;
	logic              update_event_o;
	logic              compare_match_o;
	int                failures              = 0;
	int                comparisons           = 0;
	int                cycles                = 0;
	int                t0;

	// The block under test, every port tied to the bench signal of the same name.
	timer_timebase_and_channel0_value i_dut (
		.core_clk_i, .reset_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .counter_enable_i, .update_request_i,
		.channel0_input_mode_i, .channel0_shadow_en_i, .capture_event_i,
		.update_event_o, .compare_match_o
	);

	// A 50 MHz clock and a cycle count used to time the update period.
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) cycles <= cycles + 1;

	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic reg_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge core_clk_i);
		reg_addr_i  <= addr;
		reg_wdata_i <= data;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the read edge, so they are sampled mid-cycle.
	task automatic reg_check(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
		@(posedge core_clk_i);
		reg_addr_i <= addr;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b0;
		@(negedge core_clk_i);
		check_word(reg_rdata_o, exp);
	endtask : reg_check

	task automatic pulse_update;
		@(posedge core_clk_i);
		update_request_i <= 1'b1;
		@(posedge core_clk_i);
		update_request_i <= 1'b0;
	endtask : pulse_update

	// Enables counting for exactly n clock edges.
	task automatic run_count(input int n);
		@(posedge core_clk_i);
		counter_enable_i <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		counter_enable_i <= 1'b0;
	endtask : run_count

	task automatic wait_update;
		int n;
		n = 0;
		@(negedge core_clk_i);
		while (update_event_o !== 1'b1)
		begin
			n++;
			if (n > 40)
			begin
				failures++;
				$display("unexpected at %0t: no update event", $time);
				final_report();
			end
			@(negedge core_clk_i);
		end
	endtask : wait_update

	task automatic settle_match(input logic exp);
		repeat (3) @(negedge core_clk_i);
		check_bit(compare_match_o, exp);
	endtask : settle_match

	// Main sequence: reset values, counter, prescaler, wrap, capture, compare, enable and reset.
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		reg_check(OFFSET_COUNTER_VALUE, RESET_WORD);
		reg_check(OFFSET_PRESCALER_DIVISOR, RESET_WORD);
		reg_check(OFFSET_AUTO_RELOAD_LIMIT, RESET_WORD);
		reg_check(OFFSET_CHANNEL0_MATCH_VALUE, RESET_WORD);
		reg_check(8'h30, UNMAPPED_READ);
		reg_write(OFFSET_COUNTER_VALUE, 32'h0000abcd);
		reg_check(OFFSET_COUNTER_VALUE, 32'h0000abcd);
		reg_write(OFFSET_AUTO_RELOAD_LIMIT, 32'h0000ffff);
		reg_check(OFFSET_AUTO_RELOAD_LIMIT, 32'h0000ffff);
		reg_write(OFFSET_PRESCALER_DIVISOR, 32'h00000002);
		reg_check(OFFSET_PRESCALER_DIVISOR, 32'h00000002);
		reg_write(OFFSET_COUNTER_VALUE, RESET_WORD);
		run_count(5);
		reg_check(OFFSET_COUNTER_VALUE, 32'h00000005);
		pulse_update();
		run_count(9);
		reg_check(OFFSET_COUNTER_VALUE, 32'h00000003);
		reg_write(OFFSET_PRESCALER_DIVISOR, RESET_WORD);
		reg_write(OFFSET_AUTO_RELOAD_LIMIT, 32'h00000002);
		pulse_update();
		counter_enable_i <= 1'b1;
		wait_update();
		t0 = cycles;
		wait_update();
		check_word(32'(cycles - t0), 32'h00000003);
		@(posedge core_clk_i);
		counter_enable_i <= 1'b0;
		reg_write(OFFSET_AUTO_RELOAD_LIMIT, 32'h0000ffff);
		channel0_input_mode_i <= 1'b1;
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000001);
		@(posedge core_clk_i);
		capture_event_i <= 1'b1;
		@(posedge core_clk_i);
		capture_event_i <= 1'b0;
		reg_check(OFFSET_CHANNEL0_MATCH_VALUE, 32'h00000001);
		reg_write(OFFSET_CHANNEL0_MATCH_VALUE, 32'h00000055);
		reg_check(OFFSET_CHANNEL0_MATCH_VALUE, 32'h00000001);
		@(posedge core_clk_i);
		channel0_input_mode_i <= 1'b0;
		reg_write(OFFSET_CHANNEL0_MATCH_VALUE, 32'h00000002);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000002);
		settle_match(1'b1);
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000001);
		settle_match(1'b0);
		@(posedge core_clk_i);
		channel0_shadow_en_i <= 1'b1;
		reg_write(OFFSET_CHANNEL0_MATCH_VALUE, 32'h00000001);
		settle_match(1'b0);
		pulse_update();
		reg_write(OFFSET_COUNTER_VALUE, 32'h00000001);
		settle_match(1'b1);
		// A low clock enable must hold the count although counting is requested.
		@(posedge core_clk_i);
		clk_en_i <= 1'b0;
		run_count(4);
		clk_en_i <= 1'b1;
		reg_check(OFFSET_COUNTER_VALUE, 32'h00000001);
		// A second reset in mid-run clears the count and the channel 0 value.
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		@(posedge core_clk_i);
		reset_n_i <= 1'b1;
		reg_check(OFFSET_COUNTER_VALUE, RESET_WORD);
		reg_check(OFFSET_CHANNEL0_MATCH_VALUE, RESET_WORD);
		final_report();
	end
endmodule : testbench

`default_nettype wire
